// [sio_consts.svh]
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH

// ==========================================================================
// register byte addresses, low byte at even address
// ==========================================================================
`define SIO_ADDR_ALM 7'h2e
`define SIO_ADDR_DAC 7'h30
`define SIO_ADDR_PIN 7'h32
`define SIO_ADDR_MSC 7'h34
`define SIO_ADDR_SMPL 7'h36
`define SIO_ADDR_DIAG 7'h3c
`define SIO_ADDR_CMD 7'h3e

// ==========================================================================
// field positions
// ==========================================================================
`define SIO_PIN_DIR_LSB 0
`define SIO_PIN_DAT_LSB 8
`define SIO_MSC_MEMTEST 11
`define SIO_MSC_SELFTEST 10
`define SIO_MSC_STIM_NEG 9
`define SIO_MSC_STIM_POS 8
`define SIO_MSC_BIAS_COMP 7
`define SIO_MSC_POP_ALIGN 6
`define SIO_MSC_DR_EN 2
`define SIO_MSC_DR_POL 1
`define SIO_MSC_DR_SEL 0
`define SIO_ALM_OUT_EN 2
`define SIO_ALM_OUT_POL 1
`define SIO_ALM_OUT_SEL 0
`define SIO_CMD_DAC_LATCH 2
`define SIO_DIAG_ST_ERR 5
`define SIO_DIAG_FLASH 6
`define SIO_DIAG_GYRO 10
`define SIO_DIAG_ACC_LSB 13

// ==========================================================================
// writable bit masks and reset values
// ==========================================================================
`define SIO_PIN_MASK 16'h0f0f
`define SIO_MSC_MASK 16'h0fc7
`define SIO_ALM_MASK 16'hffd7
`define SIO_DAC_MASK 16'h0fff
`define SIO_SMPL_MASK 16'h00ff
`define SIO_PIN_RST 16'h0000
`define SIO_MSC_RST 16'h0006
`define SIO_ALM_RST 16'h0000
`define SIO_DAC_RST 16'h0000
`define SIO_SMPL_RST 16'h0001
`define SIO_SMPL_EXT 8'h00

// ==========================================================================
// timing
// ==========================================================================
`define SIO_CLK_KHZ 10000
`define SIO_DR_MIN_US 100
`define SIO_DR_MAX_US 200
`define SIO_DR_PULSE_US 150
`define SIO_DR_PULSE_CYC ((`SIO_DR_PULSE_US * `SIO_CLK_KHZ) / 1000)
`define SIO_SELFTEST_MS 35
`define SIO_SELFTEST_CYC (`SIO_SELFTEST_MS * `SIO_CLK_KHZ)

`endif

// [sio_ctrl.sv]
`include "sio_consts.svh"

// Contract
// - line function priority: data-ready over alarm output over general-purpose setting.
// - pin control bits 3..0 set direction per line, one means output.
// - output lines drive data bits 11..8; input lines read back pin levels.
// - sample period bits 7..0 zero selects external sampling clock.
// - after reset data-ready is active high on line one.
// - misc bit 2 enables data-ready, bit 1 polarity, bit 0 line.
// - data-ready pulse lasts between 100 and 200 microseconds.
// - misc bit 11 starts memory test, clears itself when done.
// - misc bit 10 runs self-test, posts flags within 35 ms, clears itself.
// - misc bits 9 and 8 apply negative and positive stimulus while set.
// - misc bit 7 enables gyro linear acceleration bias compensation.
// - misc bit 6 enables accelerometer point-of-percussion alignment.
// - DAC holding writes leave output alone until latch copies both bytes.
// - DAC holding keeps 12-bit offset binary code in bits 11..0.
// - command bit 2 latches the DAC and reads back as zero.
// - alarm output uses enable bit 2, polarity bit 1, line bit 0.
module sio_ctrl #(
  parameter int unsigned P_SELFTEST_CYC = `SIO_SELFTEST_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  input wire logic [3:0] i_io_line,
  output logic [3:0] o_io_line,
  output logic [3:0] o_io_line_oe,
  input wire logic i_ext_clk,
  input wire logic i_sample_tick,
  input wire logic i_alarm_active,
  input wire sio_pkg::sio_st_res_t i_selftest_res,
  input wire logic i_memtest_done,
  input wire logic i_memtest_fail,
  output logic o_sample_strobe,
  output logic o_ext_clk_sel,
  output logic [11:0] o_dac_code,
  output logic o_selftest_run,
  output logic o_stim_neg,
  output logic o_stim_pos,
  output logic o_bias_comp_en,
  output logic o_pop_align_en,
  output logic o_memtest_run
);
  import sio_pkg::*;

  // ==========================================================================
  // declarations
  // ==========================================================================
  sio_cmd_t rx_cmd;
  logic rx_toggle;
  logic [5:0] sync_q;
  logic tog_d;
  logic ext_d;
  logic [15:0] tx_word;
  logic [15:0] pin_ctl;
  logic [15:0] msc;
  logic [15:0] smpl;
  logic [15:0] alm;
  logic [15:0] dac_hold;
  logic [15:0] diag;
  logic [10:0] dr_cnt;
  logic [18:0] st_cnt;
  sio_st_t st_state;
  sio_st_t next_st_state;
  logic [3:0] pin_level;
  logic [3:0] next_io_line;
  logic [3:0] next_io_oe;

  // ==========================================================================
  // serial link and synchronisers
  // ==========================================================================
  // a frame cut short never flips the toggle, so it is dropped
  sio_spi_link u_link (
    .i_sys_rst(i_sys_rst),
    .i_spi_sclk(i_spi_sclk),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_mosi(i_spi_mosi),
    .i_tx_word(tx_word),
    .o_spi_miso(o_spi_miso),
    .o_rx_cmd(rx_cmd),
    .o_rx_toggle(rx_toggle)
  );

  // pin levels, external clock and frame toggle all cross here
  sio_sync #(
    .W(6)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_d({rx_toggle, i_ext_clk, i_io_line}),
    .o_q(sync_q)
  );

  // delayed copies for edge detection on toggle and external clock
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tog_d <= 1'b0;
      ext_d <= 1'b0;
    end else if (i_clk_en) begin
      tog_d <= sync_q[5];
      ext_d <= sync_q[4];
    end
  end

  // ==========================================================================
  // command decode
  // ==========================================================================
  // rx_cmd is held steady for a whole frame after the toggle moves
  wire cmd_stb = i_clk_en & (sync_q[5] ^ tog_d);
  wire wr_stb = cmd_stb & rx_cmd.wr;
  wire rd_stb = cmd_stb & ~rx_cmd.wr;
  // either byte address selects the whole word for reads
  wire [6:0] reg_a = {rx_cmd.addr[6:1], 1'b0};
  wire hi_byte = rx_cmd.addr[0];
  wire [15:0] wr_data = hi_byte ? {rx_cmd.data, 8'h00} : {8'h00, rx_cmd.data};
  wire [15:0] wr_lanes = hi_byte ? 16'hff00 : 16'h00ff;

  wire hit_pin = reg_a == `SIO_ADDR_PIN;
  wire hit_msc = reg_a == `SIO_ADDR_MSC;
  wire hit_smpl = reg_a == `SIO_ADDR_SMPL;
  wire hit_alm = reg_a == `SIO_ADDR_ALM;
  wire hit_dac = reg_a == `SIO_ADDR_DAC;
  wire hit_diag = reg_a == `SIO_ADDR_DIAG;
  wire hit_cmd = reg_a == `SIO_ADDR_CMD;

  // one byte lane per write; each 16-bit value takes two writes
  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [15:0] wmask,
                                             input logic [15:0] lanes, input logic [15:0] data);
    logic [15:0] m;
    m = lanes & wmask;
    byte_merge = (old & ~m) | (data & m);
  endfunction

  // unused bits stay zero through the masks
  wire [15:0] pin_wr = byte_merge(pin_ctl, `SIO_PIN_MASK, wr_lanes, wr_data);
  wire [15:0] msc_wr = byte_merge(msc, `SIO_MSC_MASK, wr_lanes, wr_data);
  wire [15:0] smpl_wr = byte_merge(smpl, `SIO_SMPL_MASK, wr_lanes, wr_data);
  wire [15:0] alm_wr = byte_merge(alm, `SIO_ALM_MASK, wr_lanes, wr_data);
  wire [15:0] dac_wr = byte_merge(dac_hold, `SIO_DAC_MASK, wr_lanes, wr_data);

  wire dac_latch = wr_stb & hit_cmd & ~hi_byte & rx_cmd.data[`SIO_CMD_DAC_LATCH];
  wire st_done = i_clk_en & (st_state == SIO_ST_POST);
  wire mem_done = i_clk_en & i_memtest_done;

  // ==========================================================================
  // configuration registers
  // ==========================================================================
  // the command register has no storage, it only fires the latch
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_ctl <= `SIO_PIN_RST;
      smpl <= `SIO_SMPL_RST;
      alm <= `SIO_ALM_RST;
      dac_hold <= `SIO_DAC_RST;
    end else if (wr_stb) begin
      if (hit_pin) pin_ctl <= pin_wr;
      if (hit_smpl) smpl <= smpl_wr;
      if (hit_alm) alm <= alm_wr;
      if (hit_dac) dac_hold <= dac_wr;
    end
  end

  // self-clearing bits: a host write in the same cycle wins over the clear
  wire [15:0] msc_hw_clr = {4'h0, mem_done, st_done, 10'h000};
  wire [15:0] next_msc = (wr_stb & hit_msc) ? msc_wr : (msc & ~msc_hw_clr);

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      msc <= `SIO_MSC_RST;
    end else if (i_clk_en) begin
      msc <= next_msc;
    end
  end

  // holding bytes reach the converter only through the latch
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dac_code <= 12'(`SIO_DAC_RST);
    end else if (dac_latch) begin
      o_dac_code <= dac_hold[11:0];
    end
  end

  // ==========================================================================
  // automatic self-test sequencer
  // ==========================================================================
  always_comb begin
    next_st_state = st_state;
    case (st_state)
      SIO_ST_IDLE: begin
        if (msc[`SIO_MSC_SELFTEST]) next_st_state = SIO_ST_RUN;
      end
      SIO_ST_RUN: begin
        // two cycles short, so the idle start cycle and the post cycle still land inside the budget
        if (st_cnt == 19'(P_SELFTEST_CYC - 3)) next_st_state = SIO_ST_POST;
      end
      SIO_ST_POST: begin
        next_st_state = SIO_ST_IDLE;
      end
      default: begin
        next_st_state = SIO_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_state <= SIO_ST_IDLE;
      st_cnt <= 19'h00000;
    end else if (i_clk_en) begin
      st_state <= next_st_state;
      st_cnt <= (st_state == SIO_ST_RUN) ? st_cnt + 19'h00001 : 19'h00000;
    end
  end

  // ==========================================================================
  // diagnostic flags: cleared by reading, a new verdict wins
  // ==========================================================================
  wire st_any_fail = |i_selftest_res;
  // accelerometers 15:13, gyroscope 10, summary 5
  wire [15:0] st_flags = {i_selftest_res.acc_fail, 2'b00, i_selftest_res.gyro_fail,
                          4'h0, st_any_fail, 5'h00};
  wire [15:0] diag_set = st_done ? st_flags : 16'h0000;
  wire [15:0] diag_flash = (mem_done & i_memtest_fail) ? 16'h0040 : 16'h0000;
  wire diag_rd = rd_stb & hit_diag;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      diag <= 16'h0000;
    end else if (i_clk_en) begin
      diag <= (diag_rd ? 16'h0000 : diag) | diag_set | diag_flash;
    end
  end

  // ==========================================================================
  // read path: word returned in the following frame
  // ==========================================================================
  wire [15:0] pin_rd = {4'h0, pin_level, 4'h0, pin_ctl[3:0]};
  wire [15:0] rd_mux = hit_pin ? pin_rd :
                       hit_msc ? msc :
                       hit_smpl ? smpl :
                       hit_alm ? alm :
                       hit_dac ? dac_hold :
                       hit_diag ? diag :
                       16'h0000;

  // the gap the host leaves between frames lets this settle first
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_word <= 16'h0000;
    end else if (rd_stb) begin
      tx_word <= rd_mux;
    end
  end

  // ==========================================================================
  // sampling instants and data-ready pulse
  // ==========================================================================
  wire ext_sel = smpl[7:0] == `SIO_SMPL_EXT;
  wire ext_rise = sync_q[4] & ~ext_d;
  wire samp_evt = ext_sel ? ext_rise : i_sample_tick;
  wire dr_active = dr_cnt != 11'h000;

  // fixed width, not retriggered, so it always lands inside the window
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dr_cnt <= 11'h000;
    end else if (i_clk_en) begin
      if (samp_evt && !dr_active) begin
        dr_cnt <= 11'(`SIO_DR_PULSE_CYC);
      end else if (dr_active) begin
        dr_cnt <= dr_cnt - 11'h001;
      end
    end
  end

  // ==========================================================================
  // per-line function selection
  // ==========================================================================
  // only lines one and two can be claimed by data-ready or alarm
  for (genvar i = 0; i < 4; i++) begin : g_line
    localparam logic SEL = (i == 1);
    wire dr_claim = (i < 2) && msc[`SIO_MSC_DR_EN] && (msc[`SIO_MSC_DR_SEL] == SEL);
    wire alm_claim = (i < 2) && alm[`SIO_ALM_OUT_EN] && (alm[`SIO_ALM_OUT_SEL] == SEL) && !dr_claim;
    wire gp_out = pin_ctl[`SIO_PIN_DIR_LSB + i] && !dr_claim && !alm_claim;
    wire dr_lvl = ~(dr_active ^ msc[`SIO_MSC_DR_POL]);
    wire alm_lvl = ~(i_alarm_active ^ alm[`SIO_ALM_OUT_POL]);
    assign next_io_oe[i] = dr_claim | alm_claim | gp_out;
    assign next_io_line[i] = dr_claim ? dr_lvl : alm_claim ? alm_lvl :
                             gp_out & pin_ctl[`SIO_PIN_DAT_LSB + i];
    assign pin_level[i] = gp_out ? pin_ctl[`SIO_PIN_DAT_LSB + i] : sync_q[i];
  end

  // ==========================================================================
  // registered outputs
  // ==========================================================================
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_io_line <= 4'h0;
      o_io_line_oe <= 4'h0;
      o_sample_strobe <= 1'b0;
      o_ext_clk_sel <= 1'b0;
      o_selftest_run <= 1'b0;
    end else if (i_clk_en) begin
      o_io_line <= next_io_line;
      o_io_line_oe <= next_io_oe;
      o_sample_strobe <= samp_evt;
      o_ext_clk_sel <= ext_sel;
      o_selftest_run <= next_st_state == SIO_ST_RUN;
    end
  end

  // control levels follow next_msc so they move with the register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_stim_neg <= 1'b0;
      o_stim_pos <= 1'b0;
      o_bias_comp_en <= 1'b0;
      o_pop_align_en <= 1'b0;
      o_memtest_run <= 1'b0;
    end else if (i_clk_en) begin
      o_stim_neg <= next_msc[`SIO_MSC_STIM_NEG];
      o_stim_pos <= next_msc[`SIO_MSC_STIM_POS];
      o_bias_comp_en <= next_msc[`SIO_MSC_BIAS_COMP];
      o_pop_align_en <= next_msc[`SIO_MSC_POP_ALIGN];
      o_memtest_run <= next_msc[`SIO_MSC_MEMTEST];
    end
  end
endmodule // sio_ctrl

// [sio_ctrl_assertions.sv]
module sio_ctrl_assertions #(
  parameter int unsigned P_SELFTEST_CYC = 40
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_spi_cs_n,
  input wire logic i_sample_tick,
  input wire logic i_memtest_done,
  input wire logic [3:0] o_io_line,
  input wire logic [3:0] o_io_line_oe,
  input wire logic o_sample_strobe,
  input wire logic o_ext_clk_sel,
  input wire logic [11:0] o_dac_code,
  input wire logic o_selftest_run,
  input wire logic o_stim_neg,
  input wire logic o_stim_pos,
  input wire logic o_bias_comp_en,
  input wire logic o_pop_align_en,
  input wire logic o_memtest_run
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ========================================
  // helper counters
  logic [10:0] dr_cnt;
  logic [19:0] st_cnt;
  logic [4:0] idle_cnt;
  wire dr_on = o_io_line[0] & o_io_line_oe[0];
  wire [8:0] cfg = {o_stim_neg, o_stim_pos, o_bias_comp_en, o_pop_align_en, o_ext_clk_sel,
    o_io_line_oe[3:2], o_io_line[3:2]};
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dr_cnt <= '0;
      st_cnt <= '0;
      idle_cnt <= '0;
    end else begin
      dr_cnt <= dr_on ? dr_cnt + {10'h0, ~&dr_cnt} : '0;
      st_cnt <= o_selftest_run ? st_cnt + 20'h1 : '0;
      idle_cnt <= !i_spi_cs_n ? '0 : idle_cnt + {4'h0, ~&idle_cnt};
    end
  end
  // ========================================
  // properties
  property p_dr_width;
    $fell(dr_on) |-> dr_cnt >= 11'd1000 && dr_cnt <= 11'd2000;
  endproperty
  a_dr_width: assert property (p_dr_width) else $error("data-ready pulse width out of range");
  property p_strobe_tick;
    i_sample_tick && i_clk_en && !o_ext_clk_sel |=> o_sample_strobe;
  endproperty
  a_strobe_tick: assert property (p_strobe_tick) else $error("tick gave no strobe");
  property p_strobe_cause;
    !o_ext_clk_sel && !$past(o_ext_clk_sel) && $past(i_clk_en) && !$past(i_sample_tick) |-> !o_sample_strobe;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without tick");
  property p_st_len;
    $fell(o_selftest_run) |-> st_cnt == P_SELFTEST_CYC - 2;
  endproperty
  a_st_len: assert property (p_st_len) else $error("self-test run length wrong");
  property p_st_start;
    $rose(o_selftest_run) |-> idle_cnt < 5'd12;
  endproperty
  a_st_start: assert property (p_st_start) else $error("self-test started without write");
  property p_cfg_src;
    !$stable(cfg) |-> idle_cnt < 5'd12;
  endproperty
  a_cfg_src: assert property (p_cfg_src) else $error("control output moved without write");
  property p_dac_hold;
    !$stable(o_dac_code) |-> idle_cnt < 5'd12;
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("converter code moved without latch");
  property p_mem_clr;
    o_memtest_run && i_memtest_done |=> !o_memtest_run;
  endproperty
  a_mem_clr: assert property (p_mem_clr) else $error("memory test bit not cleared");
  property p_rst_dr;
    $fell(i_sys_rst) |=> o_io_line_oe[0] && !o_io_line[0];
  endproperty
  a_rst_dr: assert property (p_rst_dr) else $error("line one not idle data-ready");
  c_dr: cover property ($fell(dr_on));
  c_st: cover property ($fell(o_selftest_run));
  c_dac: cover property (!$stable(o_dac_code));
endmodule // sio_ctrl_assertions

// [sio_ctrl_tb.sv]
module sio_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sio_pkg::*;
  logic i_sys_clk = 0, i_sys_rst = 0, i_clk_en = 1, i_spi_sclk, i_spi_cs_n, i_spi_mosi, o_spi_miso;
  logic i_ext_clk = 0, i_sample_tick = 0, i_alarm_active = 0, i_memtest_done = 0, i_memtest_fail = 0;
  logic o_sample_strobe, o_ext_clk_sel, o_selftest_run, o_stim_neg, o_stim_pos;
  logic o_bias_comp_en, o_pop_align_en, o_memtest_run;
  logic [3:0] o_io_line, o_io_line_oe, ext_drv = 4'b0010;
  logic [11:0] o_dac_code;
  logic [15:0] r;
  sio_st_res_t i_selftest_res = 4'b0101;
  int n_errors = 0, comparisons = 0, n_strobe = 0, s;
  wire logic [3:0] i_io_line = (o_io_line & o_io_line_oe) | (ext_drv & ~o_io_line_oe);
  sio_ctrl #(.P_SELFTEST_CYC(40)) sio_ctrl_inst (.i_sys_clk, .i_sys_rst, .i_clk_en, .i_spi_sclk,
    .i_spi_cs_n, .i_spi_mosi, .o_spi_miso, .i_io_line, .o_io_line, .o_io_line_oe, .i_ext_clk,
    .i_sample_tick, .i_alarm_active, .i_selftest_res, .i_memtest_done, .i_memtest_fail,
    .o_sample_strobe, .o_ext_clk_sel, .o_dac_code, .o_selftest_run, .o_stim_neg, .o_stim_pos,
    .o_bias_comp_en, .o_pop_align_en, .o_memtest_run);
  sio_host_model sio_host_model_inst (.o_spi_sclk(i_spi_sclk), .o_spi_cs_n(i_spi_cs_n),
    .o_spi_mosi(i_spi_mosi), .i_spi_miso(o_spi_miso));
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (o_sample_strobe === 1'b1) n_strobe++;
  end
  // ========================================
  // access tasks
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #5;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wb(input logic [15:0] w);
    logic [15:0] d;
    sio_host_model_inst.xfer(w, d);
    cyc(8);
  endtask
  task rd(input logic [15:0] w);
    logic [15:0] d;
    sio_host_model_inst.xfer(w, d);
    sio_host_model_inst.xfer(16'h0000, r);
    cyc(2);
  endtask
  task tk;
    i_sample_tick = 1;
    cyc(1);
    i_sample_tick = 0;
  endtask
  task final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #3000000;
    n_errors++;
    final_report;
  end
  // ========================================
  // scenarios
  initial begin
    #1;
    // a real rising edge so every async reset fires
    i_sys_rst = 1;
    cyc(16);
    i_sys_rst = 0;
    cyc(4);
    rd(16'h3400); chk("misc", 16'h0006, r);
    rd(16'h3600); chk("smpl", 16'h0001, r);
    rd(16'h2000); chk("unmapped", 16'h0000, r);
    tk; cyc(4); chk("dr line one", 16'h0003, 16'({o_io_line_oe[0], o_io_line[0]}));
    cyc(2100); chk("strobes", 16'h0001, 16'(n_strobe));
    wb(16'hb20c); wb(16'hb3f8);
    chk("oe", 16'h000d, 16'(o_io_line_oe));
    chk("out", 16'h0002, 16'(o_io_line[3:2]));
    rd(16'h3200); chk("pin", 16'h0a0c, r);
    ext_drv = 4'b0000; cyc(4);
    rd(16'h3200); chk("pin sync", 16'h080c, r);
    i_alarm_active = 1; wb(16'hae07);
    chk("alarm two", 16'h0003, 16'({o_io_line_oe[1], o_io_line[1]}));
    wb(16'hae06); chk("dr over alarm", 16'h0000, 16'(o_io_line[0]));
    i_alarm_active = 0; wb(16'hb405);
    chk("dr two idle", 16'h0003, 16'({o_io_line_oe[1], o_io_line[1]}));
    tk; cyc(4); chk("dr two low", 16'h0000, 16'(o_io_line[1]));
    cyc(1600);
    wb(16'hb600); chk("ext sel", 16'h0001, 16'(o_ext_clk_sel));
    s = n_strobe; tk; cyc(6); chk("no tick", 16'(s), 16'(n_strobe));
    i_ext_clk = 1; cyc(10); i_ext_clk = 0; chk("ext strobe", 16'(s + 1), 16'(n_strobe));
    wb(16'hb601); chk("int sel", 16'h0000, 16'(o_ext_clk_sel));
    i_clk_en = 0; s = n_strobe; tk; cyc(3); i_clk_en = 1; cyc(2);
    chk("frozen", 16'(s), 16'(n_strobe));
    wb(16'hb0d9); wb(16'hb1f3);
    rd(16'h3000); chk("dac hold", 16'h03d9, r);
    chk("dac out", 16'h0000, 16'(o_dac_code));
    wb(16'hbe04); chk("dac latch", 16'h03d9, 16'(o_dac_code));
    rd(16'h3e00); chk("cmd", 16'h0000, r);
    wb(16'hb504); chk("st run", 16'h0001, 16'(o_selftest_run));
    cyc(45); chk("st done", 16'h0000, 16'(o_selftest_run));
    rd(16'h3400); chk("misc st", 16'h0005, r);
    rd(16'h3c00); chk("diag st", 16'h4420, r);
    wb(16'hb508); chk("mem run", 16'h0001, 16'(o_memtest_run));
    i_memtest_fail = 1; i_memtest_done = 1; cyc(1); i_memtest_done = 0; cyc(2);
    chk("mem done", 16'h0000, 16'(o_memtest_run));
    rd(16'h3400); chk("misc mem", 16'h0005, r);
    rd(16'h3c00); chk("diag mem", 16'h0040, r);
    foreach (ext_drv[k]) begin
      if (k < 3) begin
        wb(16'hb500 | 16'(2 - k)); chk("stim", 16'(2 - k), 16'({o_stim_neg, o_stim_pos}));
      end
    end
    wb(16'hb500); chk("stim clr", 16'h0000, 16'({o_stim_neg, o_stim_pos}));
    wb(16'hb4c5); chk("comp", 16'h0003, 16'({o_bias_comp_en, o_pop_align_en}));
    wb(16'hb405); chk("comp off", 16'h0000, 16'({o_bias_comp_en, o_pop_align_en}));
    final_report;
  end
endmodule // sio_ctrl_tb
bind sio_ctrl sio_ctrl_assertions #(.P_SELFTEST_CYC(P_SELFTEST_CYC)) sio_ctrl_assertions_inst (
  .i_sys_clk, .i_sys_rst, .i_clk_en, .i_spi_cs_n, .i_sample_tick, .i_memtest_done, .o_io_line, .o_io_line_oe,
  .o_sample_strobe, .o_ext_clk_sel, .o_dac_code, .o_selftest_run, .o_stim_neg, .o_stim_pos,
  .o_bias_comp_en, .o_pop_align_en, .o_memtest_run);

// [sio_host_model.sv]
module sio_host_model (
  output logic o_spi_sclk,
  output logic o_spi_cs_n,
  output logic o_spi_mosi,
  input wire logic i_spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_spi_sclk = 1'b1;
    o_spi_cs_n = 1'b0;
    o_spi_mosi = 1'b0;
    #1;
    // a real rising select clears the link's bit counter
    o_spi_cs_n = 1'b1;
  end
  // ========================================
  // one 16-bit mode 3 frame, clock idles high
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = '0;
    o_spi_cs_n = 1'b0;
    #43.7;
    for (int i = 15; i >= 0; i--) begin
      o_spi_sclk = 1'b0;
      o_spi_mosi = w[i];
      #62.5;
      o_spi_sclk = 1'b1;
      r[i] = i_spi_miso;
      #62.5;
    end
    o_spi_cs_n = 1'b1;
    o_spi_mosi = ~w[0];
    #2000;
  endtask
endmodule // sio_host_model

// [sio_pkg.sv]
package sio_pkg;

  // one decoded serial command word
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } sio_cmd_t;

  // per-sensor self-test verdicts
  typedef struct packed {
    logic [2:0] acc_fail;
    logic gyro_fail;
  } sio_st_res_t;

  typedef enum logic [2:0] {
    SIO_ST_IDLE = 3'b001,
    SIO_ST_RUN = 3'b010,
    SIO_ST_POST = 3'b100
  } sio_st_t;

endpackage

// [sio_spi_link.sv]
module sio_spi_link (
  input wire logic i_sys_rst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic [15:0] i_tx_word,
  output logic o_spi_miso,
  output sio_pkg::sio_cmd_t o_rx_cmd,
  output logic o_rx_toggle
);
  import sio_pkg::*;

  logic [3:0] bit_cnt;
  logic [14:0] rx_sh;
  logic [15:0] tx_sh;

  // ==========================================================================
  // receive: sample on rising edge, frame restarts while select is high
  // ==========================================================================
  always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      bit_cnt <= 4'h0;
      rx_sh <= 15'h0000;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      rx_sh <= {rx_sh[13:0], i_spi_mosi};
    end
  end

  // word held stable until the next 16th edge; toggle marks it
  always_ff @(posedge i_spi_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_cmd <= '0;
      o_rx_toggle <= 1'b0;
    end else if (!i_spi_cs_n && bit_cnt == 4'hf) begin
      o_rx_cmd <= {rx_sh, i_spi_mosi};
      o_rx_toggle <= ~o_rx_toggle;
    end
  end

  // ==========================================================================
  // transmit: shift out on falling edge, reload at each word boundary
  // ==========================================================================
  always_ff @(negedge i_spi_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_spi_miso <= 1'b0;
      tx_sh <= 16'h0000;
    end else if (bit_cnt == 4'h0) begin
      o_spi_miso <= i_tx_word[15];
      tx_sh <= {i_tx_word[14:0], 1'b0};
    end else begin
      o_spi_miso <= tx_sh[15];
      tx_sh <= {tx_sh[14:0], 1'b0};
    end
  end
endmodule // sio_spi_link

// [sio_sync.sv]
module sio_sync #(
  parameter int W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // ==========================================================================
  // two-flop synchroniser per bit
  // ==========================================================================
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        meta[b] <= 1'b0;
        o_q[b] <= 1'b0;
      end else if (i_clk_en) begin
        meta[b] <= i_d[b];
        o_q[b] <= meta[b];
      end
    end
  end
endmodule // sio_sync
